// ### dtt_pkg.sv
// What this block does
// - qualify in order: arm on the arm edge, wait the delay, then fire on trigger edge.
// - delay counts either elapsed time or trigger-source edge events, selected by software.
// - interval starts at arming; trigger edges are searched only after it expires.
// - interactive knob delay is clamped to 30 ns up to 160 ms.
// - programmed delay in ns is accepted from 5 ns to 10 s, else refused.
// - one comparator level serves both arm and trigger edges; no trigger level exists.
// - software picks the arm source: analog channel, logic input or external input.
// - arm edge polarity is selectable, rising or falling.
// - trigger source is chosen independently of the arm source.
// - trigger edge polarity has its own rising or falling selection.
// - in event mode the trigger edge polarity is likewise selectable.
// - analog 1-2 or 1-4 by variant, external only on two-channel, sixteen logic inputs.
// - holdoff and noise-reject filtering condition the trigger decisions.
// - every source, polarity and committed delay setting reads back as last accepted, the delay low word as staged; knob delay writes read back clamped.
// - event count after arming is programmable from zero to sixteen million.
package dtt_pkg;
    // source codes: analog ch1..ch4, logic inputs 0..15, external
    localparam int SRC_COUNT = 21;
    localparam logic [4:0] SRC_ANALOG_FIRST = 5'h00;
    localparam logic [4:0] SRC_LOGIC_FIRST = 5'h04;
    localparam logic [4:0] SRC_LOGIC_LAST = 5'h13;
    localparam logic [4:0] SRC_EXTERNAL = 5'h14;
    localparam logic [4:0] ANALOG_COUNT_TWO = 5'h02;
    localparam logic [4:0] ANALOG_COUNT_FOUR = 5'h04;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_ARM_SOURCE = 8'h04;
    localparam logic [7:0] OFS_ARM_POLARITY = 8'h08;
    localparam logic [7:0] OFS_TRIG_SOURCE = 8'h0C;
    localparam logic [7:0] OFS_TRIG_POLARITY = 8'h10;
    localparam logic [7:0] OFS_DELAY_LOW = 8'h14;
    localparam logic [7:0] OFS_DELAY_HIGH = 8'h18;
    localparam logic [7:0] OFS_DELAY_KNOB = 8'h1C;
    localparam logic [7:0] OFS_EVENT_COUNT = 8'h20;
    localparam logic [7:0] OFS_LEVEL = 8'h24;
    localparam logic [7:0] OFS_HOLDOFF = 8'h28;
    localparam logic [7:0] OFS_NOISE = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    localparam logic [7:0] OFS_FIRE_COUNT = 8'h34;
    // field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_EVENT_MODE_BIT = 1;
    localparam int STAT_BAD_WRITE_BIT = 4;
    // reset values
    localparam logic [33:0] DELAY_RESET_NS = 34'h0_0000_0064;
    localparam logic [4:0] SRC_RESET = 5'h00;
    localparam logic POL_RESET_RISING = 1'b1;
    // times in ns and counts
    localparam logic [33:0] CLK_PERIOD_NS = 34'h0_0000_000A;
    localparam logic [31:0] KNOB_MIN_NS = 32'h0000_001E;
    localparam logic [31:0] KNOB_MAX_NS = 32'h0989_6800;
    localparam logic [33:0] PROG_MIN_NS = 34'h0_0000_0005;
    localparam logic [33:0] PROG_MAX_NS = 34'h2_540B_E400;
    localparam logic [23:0] EVENT_MAX = 24'hF4_2400;
    localparam int NOISE_FILTER_NS = 30;
    localparam int NOISE_CYCLES = (NOISE_FILTER_NS + 9) / 10;
endpackage : dtt_pkg

// ### dtt_edge_pick.sv
`timescale 1ns/10ps
module dtt_edge_pick
    import dtt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // synchronised comparator and logic levels
    input wire logic [SRC_COUNT-1:0] srcLevels,
    // selection
    input wire logic [4:0] sel,
    input wire logic rising,
    input wire logic noiseReject,
    // result
    output logic edgePulse
);
    logic picked;
    logic filt_reg;
    logic prev_reg;
    logic [3:0] stable_reg;

    assign picked = (sel < 5'(SRC_COUNT)) ? srcLevels[sel] : 1'b0;

    // level only follows once steady for the filter time
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filt_reg <= 1'b0;
            stable_reg <= 4'h0;
        end else if (!noiseReject || picked == filt_reg) begin
            stable_reg <= 4'h0;
            if (!noiseReject) filt_reg <= picked;
        end else if (stable_reg >= 4'(NOISE_CYCLES - 1)) begin
            filt_reg <= picked;
            stable_reg <= 4'h0;
        end else begin
            stable_reg <= stable_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) prev_reg <= 1'b0;
        else prev_reg <= filt_reg;
    end

    // rising or falling as selected
    assign edgePulse = rising ? (filt_reg & ~prev_reg) : (~filt_reg & prev_reg);
endmodule : dtt_edge_pick

// ### dtt_holdoff_timer.sv
`timescale 1ns/10ps
module dtt_holdoff_timer
    import dtt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic start,
    input wire logic [23:0] cycles,
    // status
    output logic busy
);
    logic [23:0] count_reg;

    // blocks re-arming for the holdoff after each fire
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) count_reg <= 24'h00_0000;
        else if (start) count_reg <= cycles;
        else if (count_reg != 24'h00_0000) count_reg <= count_reg - 24'h00_0001;
    end

    assign busy = (count_reg != 24'h00_0000);
endmodule : dtt_holdoff_timer

// ### dtt_delay_trigger.sv
`timescale 1ns/10ps
module dtt_delay_trigger
    import dtt_pkg::*;
#(
    parameter bit TWO_CHANNEL = 1'b0,
    parameter bit LOGIC_FITTED = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // comparator outputs, logic inputs, external input (asynchronous)
    input wire logic [3:0] analogCompare,
    input wire logic [15:0] logicInput,
    input wire logic externalCompare,
    // shared comparator level
    output logic [15:0] compLevel,
    // trigger result
    output logic trigOut,
    output logic armed
);
    typedef enum logic [2:0] {
        DTT_IDLE,
        DTT_ARM_WAIT,
        DTT_DELAYING,
        DTT_SEARCH,
        DTT_HOLDOFF
    } dtt_state_t;

    dtt_state_t state_reg;
    dtt_state_t state_next;

    logic [SRC_COUNT-1:0] srcMeta_reg;
    logic [SRC_COUNT-1:0] srcSync_reg;
    logic enable_reg;
    logic eventMode_reg;
    logic [4:0] armSource_reg;
    logic armRising_reg;
    logic [4:0] trigSource_reg;
    logic trigRising_reg;
    logic [33:0] delayNs_reg;
    logic [31:0] delayStage_reg;
    logic [23:0] eventTarget_reg;
    logic [15:0] level_reg;
    logic [23:0] holdoff_reg;
    logic noiseReject_reg;
    logic badWrite_reg;
    logic [31:0] fireCount_reg;
    logic [33:0] elapsed_reg;
    logic [23:0] eventSeen_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic trig_reg;

    logic wrEn;
    logic rdEn;
    logic armEdge;
    logic trigEdge;
    logic holdBusy;
    logic fireNow;
    logic delayDone;
    logic [33:0] elapsedPlus;
    logic [33:0] progCandidate;
    logic progOk;
    logic [31:0] knobClamped;
    logic [31:0] curWord;
    logic [31:0] wrWord;
    logic badSet;

    function automatic logic srcValid(input logic [4:0] code);
        logic [4:0] analogLimit;
        analogLimit = TWO_CHANNEL ? ANALOG_COUNT_TWO : ANALOG_COUNT_FOUR;
        if (code < SRC_LOGIC_FIRST) srcValid = (code - SRC_ANALOG_FIRST) < analogLimit;
        else if (code <= SRC_LOGIC_LAST) srcValid = LOGIC_FITTED;
        else if (code == SRC_EXTERNAL) srcValid = TWO_CHANNEL;
        else srcValid = 1'b0;
    endfunction : srcValid

    // ---------------- input synchroniser ----------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            srcMeta_reg <= '0;
            srcSync_reg <= '0;
        end else begin
            srcMeta_reg <= {externalCompare, logicInput, analogCompare};
            srcSync_reg <= srcMeta_reg;
        end
    end

    // ---------------- edge detectors ----------------
    // arm and trigger pickers are independent
    dtt_edge_pick armPick (
        .clk(clk),
        .arst_n(arst_n),
        .srcLevels(srcSync_reg),
        .sel(armSource_reg),
        .rising(armRising_reg),
        .noiseReject(noiseReject_reg),
        .edgePulse(armEdge)
    );

    dtt_edge_pick trigPick (
        .clk(clk),
        .arst_n(arst_n),
        .srcLevels(srcSync_reg),
        .sel(trigSource_reg),
        .rising(trigRising_reg),
        .noiseReject(noiseReject_reg),
        .edgePulse(trigEdge)
    );

    dtt_holdoff_timer holdTimer (
        .clk(clk),
        .arst_n(arst_n),
        .start(fireNow),
        .cycles(holdoff_reg),
        .busy(holdBusy)
    );

    // ---------------- bus slave ----------------
    assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
    assign rdEn = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;

    always_comb begin
        unique case (wb_adr_i)
            OFS_CONTROL: curWord = {30'h0000_0000, eventMode_reg, enable_reg};
            OFS_ARM_SOURCE: curWord = {27'h000_0000, armSource_reg};
            OFS_ARM_POLARITY: curWord = {31'h0000_0000, armRising_reg};
            OFS_TRIG_SOURCE: curWord = {27'h000_0000, trigSource_reg};
            OFS_TRIG_POLARITY: curWord = {31'h0000_0000, trigRising_reg};
            OFS_DELAY_LOW: curWord = delayStage_reg;
            OFS_DELAY_HIGH: curWord = {30'h0000_0000, delayNs_reg[33:32]};
            OFS_DELAY_KNOB: curWord = delayNs_reg[31:0];
            OFS_EVENT_COUNT: curWord = {8'h00, eventTarget_reg};
            OFS_LEVEL: curWord = {16'h0000, level_reg};
            OFS_HOLDOFF: curWord = {8'h00, holdoff_reg};
            OFS_NOISE: curWord = {31'h0000_0000, noiseReject_reg};
            OFS_STATUS: curWord = {27'h000_0000, badWrite_reg, holdBusy, 3'(state_reg)};
            OFS_FIRE_COUNT: curWord = fireCount_reg;
            default: curWord = 32'h0000_0000;
        endcase
    end

    // byte lanes merged over the current contents
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wrWord[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : curWord[i*8 +: 8];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) ack_reg <= 1'b0;
        else ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rdata_reg <= 32'h0000_0000;
        else if (rdEn) rdata_reg <= curWord;
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ---------------- configuration registers ----------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= 1'b0;
            eventMode_reg <= 1'b0;
        end else if (wrEn && wb_adr_i == OFS_CONTROL) begin
            enable_reg <= wrWord[CTRL_ENABLE_BIT];
            eventMode_reg <= wrWord[CTRL_EVENT_MODE_BIT];
        end
    end

    // sources only take codes the variant has
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armSource_reg <= SRC_RESET;
            trigSource_reg <= SRC_RESET;
        end else if (wrEn) begin
            if (wb_adr_i == OFS_ARM_SOURCE && srcValid(wrWord[4:0])) armSource_reg <= wrWord[4:0];
            if (wb_adr_i == OFS_TRIG_SOURCE && srcValid(wrWord[4:0])) trigSource_reg <= wrWord[4:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armRising_reg <= POL_RESET_RISING;
            trigRising_reg <= POL_RESET_RISING;
        end else if (wrEn) begin
            if (wb_adr_i == OFS_ARM_POLARITY) armRising_reg <= wrWord[0];
            if (wb_adr_i == OFS_TRIG_POLARITY) trigRising_reg <= wrWord[0];
        end
    end

    assign progCandidate = {wrWord[1:0], delayStage_reg};
    assign progOk = (progCandidate >= PROG_MIN_NS) && (progCandidate <= PROG_MAX_NS);
    always_comb begin
        if (wrWord < KNOB_MIN_NS) knobClamped = KNOB_MIN_NS;
        else if (wrWord > KNOB_MAX_NS) knobClamped = KNOB_MAX_NS;
        else knobClamped = wrWord;
    end

    // low word stages, high word commits the whole programmed delay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            delayStage_reg <= DELAY_RESET_NS[31:0];
            delayNs_reg <= DELAY_RESET_NS;
        end else if (wrEn) begin
            if (wb_adr_i == OFS_DELAY_LOW) delayStage_reg <= wrWord;
            if (wb_adr_i == OFS_DELAY_HIGH && progOk) delayNs_reg <= progCandidate;
            if (wb_adr_i == OFS_DELAY_KNOB) begin
                delayNs_reg <= {2'b00, knobClamped};
                delayStage_reg <= knobClamped;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) eventTarget_reg <= 24'h00_0000;
        else if (wrEn && wb_adr_i == OFS_EVENT_COUNT && wrWord <= {8'h00, EVENT_MAX}) eventTarget_reg <= wrWord[23:0];
    end

    // one level for both edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) level_reg <= 16'h0000;
        else if (wrEn && wb_adr_i == OFS_LEVEL) level_reg <= wrWord[15:0];
    end

    assign compLevel = level_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            holdoff_reg <= 24'h00_0000;
            noiseReject_reg <= 1'b0;
        end else if (wrEn) begin
            if (wb_adr_i == OFS_HOLDOFF) holdoff_reg <= wrWord[23:0];
            if (wb_adr_i == OFS_NOISE) noiseReject_reg <= wrWord[0];
        end
    end

    // refused writes are flagged; a new refusal wins over the clear
    always_comb begin
        badSet = 1'b0;
        if (wrEn) begin
            if ((wb_adr_i == OFS_ARM_SOURCE || wb_adr_i == OFS_TRIG_SOURCE) && !srcValid(wrWord[4:0])) badSet = 1'b1;
            if (wb_adr_i == OFS_DELAY_HIGH && !progOk) badSet = 1'b1;
            if (wb_adr_i == OFS_EVENT_COUNT && wrWord > {8'h00, EVENT_MAX}) badSet = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) badWrite_reg <= 1'b0;
        else if (badSet) badWrite_reg <= 1'b1;
        else if (wrEn && wb_adr_i == OFS_STATUS && wrWord[STAT_BAD_WRITE_BIT]) badWrite_reg <= 1'b0;
    end

    // ---------------- qualifier sequence ----------------
    assign elapsedPlus = elapsed_reg + CLK_PERIOD_NS;
    // time mode rounds up to whole cycles, at least one
    assign delayDone = eventMode_reg ? (eventSeen_reg >= eventTarget_reg) : (elapsedPlus >= delayNs_reg);
    assign fireNow = (state_reg == DTT_SEARCH) && trigEdge && enable_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DTT_IDLE: if (enable_reg && !holdBusy) state_next = DTT_ARM_WAIT;
            DTT_ARM_WAIT: begin
                if (!enable_reg) state_next = DTT_IDLE;
                else if (armEdge) state_next = DTT_DELAYING;
            end
            DTT_DELAYING: begin
                if (!enable_reg) state_next = DTT_IDLE;
                else if (delayDone) state_next = DTT_SEARCH;
            end
            DTT_SEARCH: begin
                if (!enable_reg) state_next = DTT_IDLE;
                else if (trigEdge) state_next = DTT_HOLDOFF;
            end
            DTT_HOLDOFF: begin
                if (!enable_reg) state_next = DTT_IDLE;
                else if (!holdBusy) state_next = DTT_ARM_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) state_reg <= DTT_IDLE;
        else state_reg <= state_next;
    end

    // interval starts at the arm edge; later arm edges are ignored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) elapsed_reg <= 34'h0_0000_0000;
        else if (state_reg == DTT_ARM_WAIT) elapsed_reg <= 34'h0_0000_0000;
        else if (state_reg == DTT_DELAYING && !delayDone) elapsed_reg <= elapsedPlus;
    end

    // event mode counts trigger-source edges after arming
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) eventSeen_reg <= 24'h00_0000;
        else if (state_reg == DTT_ARM_WAIT) eventSeen_reg <= 24'h00_0000;
        else if (state_reg == DTT_DELAYING && trigEdge && !delayDone) eventSeen_reg <= eventSeen_reg + 24'h00_0001;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) trig_reg <= 1'b0;
        else trig_reg <= fireNow;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) fireCount_reg <= 32'h0000_0000;
        else if (fireNow) fireCount_reg <= fireCount_reg + 32'h0000_0001;
    end

    assign trigOut = trig_reg;
    assign armed = (state_reg == DTT_DELAYING) || (state_reg == DTT_SEARCH);
endmodule : dtt_delay_trigger

// ### dtt_delay_trigger_chk.sv
`timescale 1ns/10ps
module dtt_delay_trigger_chk
    import dtt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // results
    input wire logic [15:0] compLevel,
    input wire logic trigOut,
    input wire logic armed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic taken;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;

    a_ack_next_cycle: assert property (taken |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_only_request: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_level_follows_write: assert property (taken && wb_we_i && wb_adr_i == OFS_LEVEL && wb_sel_i == 4'hF
        |-> ##2 compLevel == $past(wb_dat_i[15:0], 2)) else $error("shared level not updated");
    a_level_read_back: assert property (taken && !wb_we_i && wb_adr_i == OFS_LEVEL
        |=> wb_dat_o[15:0] == compLevel) else $error("level readback differs");
    a_unmapped_reads_zero: assert property (taken && !wb_we_i && wb_adr_i == 8'h40
        |=> wb_ack_o && wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    a_trig_single_pulse: assert property (trigOut |=> !trigOut)
        else $error("trigger pulse too long");
    a_trig_from_search: assert property (trigOut |-> $past(armed))
        else $error("trigger without armed qualifier");
    a_rearm_after_fire: assert property (trigOut |-> !armed)
        else $error("still armed after firing");
endmodule : dtt_delay_trigger_chk

bind dtt_delay_trigger dtt_delay_trigger_chk u_chk (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .compLevel(compLevel), .trigOut(trigOut), .armed(armed));

// ### dtt_src_model.sv
`timescale 1ns/10ps
module dtt_src_model
    import dtt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // stimulus request
    input wire logic [4:0] flipSel,
    input wire logic flip,
    // comparator and logic levels
    output logic [3:0] analogCompare,
    output logic [15:0] logicInput,
    output logic externalCompare
);
    logic [SRC_COUNT-1:0] levelReg;
    // comparators always drive; a request flips one source
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            levelReg <= '0;
        end else if (flip) begin
            levelReg[flipSel] <= ~levelReg[flipSel];
        end
    end
    assign analogCompare = levelReg[3:0];
    assign logicInput = levelReg[19:4];
    assign externalCompare = levelReg[20];
endmodule : dtt_src_model

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
    import dtt_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatW = 32'h0000_0000;
    logic [31:0] wbDatR;
    logic wbAck;
    logic [3:0] analogCompare;
    logic [15:0] logicInput;
    logic externalCompare;
    logic [15:0] compLevel;
    logic trigOut;
    logic armed;
    logic [4:0] flipSel = 5'h00;
    logic flip = 1'b0;
    int errorCnt = 0;
    int nChecks = 0;
    int cycles = 0;
    int trigCnt = 0;
    logic [7:0] rstAdr [7] = '{OFS_CONTROL, OFS_ARM_SOURCE, OFS_ARM_POLARITY, OFS_TRIG_SOURCE,
        OFS_TRIG_POLARITY, OFS_DELAY_LOW, OFS_DELAY_HIGH};
    logic [31:0] rstVal [7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000,
        32'h0000_0001, DELAY_RESET_NS[31:0], 32'h0000_0000};

    dtt_delay_trigger u_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .analogCompare(analogCompare), .logicInput(logicInput), .externalCompare(externalCompare),
        .compLevel(compLevel), .trigOut(trigOut), .armed(armed));
    dtt_src_model u_src (.clk(clk), .arst_n(arst_n), .flipSel(flipSel), .flip(flip),
        .analogCompare(analogCompare), .logicInput(logicInput), .externalCompare(externalCompare));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (trigOut === 1'b1) trigCnt <= trigCnt + 1;
        if (cycles == 20000) begin
            errorCnt = errorCnt + 1;
            finish_test();
        end
    end

    task automatic finish_test;
        if (errorCnt == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        // request held until ack is seen high at a rising edge; data taken there
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        rdat = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        xfer(1'b1, adr, dat, d);
    endtask : wr
    task automatic rd_reg(input logic [7:0] adr, output logic [31:0] d);
        xfer(1'b0, adr, 32'h0000_0000, d);
    endtask : rd_reg
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(adr, d);
        check(d, exp);
    endtask : rd_chk
    // refusal flag read, then cleared
    task automatic bad_chk(input logic e);
        logic [31:0] d;
        rd_reg(OFS_STATUS, d);
        check(32'(d[STAT_BAD_WRITE_BIT]), 32'(e));
        wr(OFS_STATUS, 32'h0000_0010);
    endtask : bad_chk
    task automatic toggle(input logic [4:0] code);
        @(posedge clk);
        flipSel <= code;
        flip <= 1'b1;
        @(posedge clk);
        flip <= 1'b0;
        // sync, edge and trigger registers settle before anyone looks
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask : toggle

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(rstAdr[i], rstVal[i]);
        wr(OFS_CONTROL, 32'h0000_0000);
        wr(OFS_ARM_SOURCE, 32'h0000_0013);
        rd_chk(OFS_ARM_SOURCE, 32'h0000_0013);
        wr(OFS_TRIG_SOURCE, 32'h0000_0003);
        rd_chk(OFS_TRIG_SOURCE, 32'h0000_0003);
        wr(OFS_ARM_SOURCE, 32'(SRC_EXTERNAL));
        rd_chk(OFS_ARM_SOURCE, 32'h0000_0013);
        bad_chk(1'b1);
        wr(OFS_TRIG_SOURCE, 32'h0000_0015);
        rd_chk(OFS_TRIG_SOURCE, 32'h0000_0003);
        bad_chk(1'b1);
        bad_chk(1'b0);
        wr(OFS_DELAY_LOW, 32'h0000_0004);
        wr(OFS_DELAY_HIGH, 32'h0000_0000);
        bad_chk(1'b1);
        wr(OFS_DELAY_LOW, 32'h0000_0005);
        wr(OFS_DELAY_HIGH, 32'h0000_0000);
        rd_chk(OFS_DELAY_KNOB, 32'h0000_0005);
        wr(OFS_DELAY_LOW, 32'h540B_E401);
        wr(OFS_DELAY_HIGH, 32'h0000_0002);
        bad_chk(1'b1);
        wr(OFS_DELAY_LOW, PROG_MAX_NS[31:0]);
        wr(OFS_DELAY_HIGH, 32'h0000_0002);
        rd_chk(OFS_DELAY_HIGH, 32'h0000_0002);
        wr(OFS_DELAY_KNOB, 32'h0000_000A);
        rd_chk(OFS_DELAY_KNOB, KNOB_MIN_NS);
        wr(OFS_DELAY_KNOB, 32'hFFFF_FFFF);
        rd_chk(OFS_DELAY_KNOB, KNOB_MAX_NS);
        rd_chk(OFS_DELAY_HIGH, 32'h0000_0000);
        wr(OFS_EVENT_COUNT, 32'(EVENT_MAX) + 32'h0000_0001);
        bad_chk(1'b1);
        wr(OFS_EVENT_COUNT, 32'(EVENT_MAX));
        rd_chk(OFS_EVENT_COUNT, 32'(EVENT_MAX));
        wr(OFS_LEVEL, 32'h0000_A5C3);
        @(negedge clk);
        check(32'(compLevel), 32'h0000_A5C3);
        rd_chk(8'h40, 32'h0000_0000);
        wr(OFS_ARM_POLARITY, 32'h0000_0000);
        rd_chk(OFS_ARM_POLARITY, 32'h0000_0000);
        // time mode: 300 ns delay, arm on channel 1, fire on first logic input
        wr(OFS_ARM_SOURCE, 32'(SRC_ANALOG_FIRST));
        wr(OFS_ARM_POLARITY, 32'h0000_0001);
        wr(OFS_TRIG_SOURCE, 32'(SRC_LOGIC_FIRST));
        wr(OFS_TRIG_POLARITY, 32'h0000_0001);
        wr(OFS_DELAY_KNOB, 32'h0000_012C);
        wr(OFS_CONTROL, 32'h0000_0001);
        toggle(SRC_ANALOG_FIRST);
        toggle(SRC_LOGIC_FIRST);
        toggle(SRC_ANALOG_FIRST);
        toggle(SRC_ANALOG_FIRST);
        check(32'(trigCnt), 32'h0000_0000);
        check(32'(armed), 32'h0000_0001);
        repeat (14) @(posedge clk);
        toggle(SRC_LOGIC_FIRST);
        check(32'(trigCnt), 32'h0000_0000);
        toggle(SRC_LOGIC_FIRST);
        check(32'(trigCnt), 32'h0000_0001);
        check(32'(armed), 32'h0000_0000);
        rd_chk(OFS_FIRE_COUNT, 32'h0000_0001);
        // event mode: falling edges, two counted before the search
        wr(OFS_CONTROL, 32'h0000_0000);
        wr(OFS_ARM_POLARITY, 32'h0000_0000);
        wr(OFS_TRIG_POLARITY, 32'h0000_0000);
        wr(OFS_EVENT_COUNT, 32'h0000_0002);
        wr(OFS_HOLDOFF, 32'h0000_0020);
        wr(OFS_CONTROL, 32'h0000_0003);
        toggle(SRC_ANALOG_FIRST);
        for (int i = 0; i < 4; i++) toggle(SRC_LOGIC_FIRST);
        check(32'(trigCnt), 32'h0000_0001);
        toggle(SRC_LOGIC_FIRST);
        check(32'(trigCnt), 32'h0000_0002);
        rd_chk(OFS_STATUS, 32'h0000_000C);
        finish_test();
    end
endmodule : testbench
